// ---- dsbe_pkg.sv ----
// Contract
// - Each positive strobe latches one lane plus flag.
// - Stop-clock inactive: output shows unmasked floating-point error.
// - Stop-clock active: output shows pending break event.
// - Break indication holds until stop-clock request drops.
// - Probe request during stop-clock counts as break.
// - Sender inverts lane when over half bits change.
package dsbe_pkg;
  localparam int LANES      = 4;
  localparam int LANE_W     = 16;
  localparam int BUS_W      = LANES * LANE_W;
  localparam int INV_HALF   = LANE_W / 2;
  localparam int BUF_DEPTH  = 2;

  typedef struct packed {
    logic [BUS_W-1:0] data;
    logic [LANES-1:0] inv;
  } dsbe_word_t;

  typedef struct packed {
    logic stop_clock_request;
    logic probe_request;
    logic fp_error;
    logic break_req;
  } dsbe_evt_t;
endpackage

// ---- dsbe_lane.sv ----
`timescale 1ns/1ps
module dsbe_lane #(
  parameter int W = 16
) (
  input  wire logic         link_clk,
  input  wire logic         rst_n,
  input  wire logic         strobe,
  input  wire logic [W-1:0] d,
  input  wire logic         inv,
  output logic [W-1:0]      q
);
  logic [W-1:0] next_q;

  // The lane flag undoes the sender's inversion so the core sees true data.
  always_comb begin
    next_q = q;
    if (strobe) begin
      next_q = inv ? ~d : d;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ---- dsbe_buf.sv ----
`timescale 1ns/1ps
module dsbe_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW-1:0] next_wp;
  logic [AW-1:0] next_rp;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt != D[AW:0]);
  assign out_valid = (cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp];

  always_comb begin
    next_wp  = push ? ((wp == AW'(D - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp  = pop ? ((rp == AW'(D - 1)) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// ---- dsbe_top.sv ----
`timescale 1ns/1ps
module dsbe_top #(
  parameter int LANES = dsbe_pkg::LANES,
  parameter int LANE_W = dsbe_pkg::LANE_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    link_clk,
  input  wire logic [LANES*LANE_W-1:0] link_data,
  input  wire logic [LANES-1:0]        lane_invert_flags,
  input  wire logic [LANES-1:0]        data_strobe_pos,
  output logic                         word_valid,
  input  wire logic                    word_ready,
  output dsbe_pkg::dsbe_word_t         word,
  output logic                         word_overrun,
  input  wire logic                    stop_clock_request_n,
  input  wire logic                    probe_request_n,
  input  wire logic                    fp_error_unmasked,
  input  wire logic                    break_event,
  output logic                         fp_error_break_pending_n
);
  localparam int BW = LANES * LANE_W;
  // Four hold slots keep a word steady for four link cycles, well past the
  // synchroniser latency, so back-to-back words never overwrite one in flight.
  localparam int HOLD_N = 4;
  localparam int HW     = 2;

  // Link domain: each strobe bit captures its own lane.
  logic [BW-1:0]    lane_q;
  logic [LANES-1:0] inv_q;
  logic [LANES-1:0] next_inv_q;
  logic [LANES-1:0] seen;
  logic [LANES-1:0] next_seen;
  logic             link_tog;
  logic             next_link_tog;
  logic [BW-1:0]    hold_data [HOLD_N];
  logic [LANES-1:0] hold_inv [HOLD_N];
  logic [BW-1:0]    next_hold_data [HOLD_N];
  logic [LANES-1:0] next_hold_inv [HOLD_N];
  logic [HW-1:0]    hold_wr;
  logic [HW-1:0]    next_hold_wr;
  logic [LANES-1:0] all_seen;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      dsbe_lane #(.W(LANE_W)) u_lane (
        .link_clk (link_clk),
        .rst_n    (rst_n),
        .strobe   (data_strobe_pos[g]),
        .d        (link_data[g*LANE_W +: LANE_W]),
        .inv      (lane_invert_flags[g]),
        .q        (lane_q[g*LANE_W +: LANE_W])
      );
    end
  endgenerate

  assign all_seen = seen | data_strobe_pos;

  // A word is complete when every lane has been strobed once; the
  // completed word is frozen in the next hold slot as the toggle flips,
  // so the system side reads stable data however the clocks line up.
  always_comb begin
    next_inv_q     = inv_q;
    next_seen      = all_seen;
    next_link_tog  = link_tog;
    next_hold_data = hold_data;
    next_hold_inv  = hold_inv;
    next_hold_wr   = hold_wr;
    for (int i = 0; i < LANES; i++) begin
      if (data_strobe_pos[i]) begin
        next_inv_q[i] = lane_invert_flags[i];
      end
    end
    if (seen == {LANES{1'b1}}) begin
      next_hold_data[hold_wr] = lane_q;
      next_hold_inv[hold_wr]  = inv_q;
      next_hold_wr   = hold_wr + HW'(1);
      next_link_tog  = ~link_tog;
      next_seen      = data_strobe_pos;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_q     <= '0;
      seen      <= '0;
      link_tog  <= 1'b0;
      hold_data <= '{default: '0};
      hold_inv  <= '{default: '0};
      hold_wr   <= '0;
    end else begin
      inv_q     <= next_inv_q;
      seen      <= next_seen;
      link_tog  <= next_link_tog;
      hold_data <= next_hold_data;
      hold_inv  <= next_hold_inv;
      hold_wr   <= next_hold_wr;
    end
  end

  // System domain: toggle synchroniser and word capture.
  logic                 tog_s1;
  logic                 tog_s2;
  logic                 tog_s3;
  logic                 new_word;
  logic                 buf_in_ready;
  logic                 next_overrun;
  logic [HW-1:0]        hold_rd;
  logic [HW-1:0]        next_hold_rd;
  dsbe_pkg::dsbe_word_t cap;
  dsbe_pkg::dsbe_word_t buf_out;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  assign new_word = tog_s2 ^ tog_s3;

  always_comb begin
    cap.data = hold_data[hold_rd];
    cap.inv  = hold_inv[hold_rd];
  end

  // A full buffer cannot refuse the link, so a dropped word is flagged
  // sticky rather than lost silently.
  always_comb begin
    next_overrun = word_overrun | (new_word & ~buf_in_ready);
    // The read slot advances on every word, dropped or not, to track the writer.
    next_hold_rd = new_word ? hold_rd + HW'(1) : hold_rd;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_overrun <= 1'b0;
      hold_rd      <= '0;
    end else begin
      word_overrun <= next_overrun;
      hold_rd      <= next_hold_rd;
    end
  end

  dsbe_buf #(.W($bits(dsbe_pkg::dsbe_word_t)), .D(dsbe_pkg::BUF_DEPTH)) u_buf (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (new_word),
    .in_ready  (buf_in_ready),
    .in_data   (cap),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (buf_out)
  );

  assign word = buf_out;

  // Error and break reporting.
  logic stop_clock_request_s1;
  logic stop_clock_request_s2;
  logic probe_request_s1;
  logic probe_request_s2;
  logic ferr_s1;
  logic ferr_s2;
  logic brk_s1;
  logic brk_s2;
  logic stop_act;
  logic break_hold;
  logic next_break_hold;
  logic next_pin_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_clock_request_s1 <= 1'b1;
      stop_clock_request_s2 <= 1'b1;
      probe_request_s1   <= 1'b1;
      probe_request_s2   <= 1'b1;
      ferr_s1   <= 1'b0;
      ferr_s2   <= 1'b0;
      brk_s1    <= 1'b0;
      brk_s2    <= 1'b0;
    end else begin
      stop_clock_request_s1 <= stop_clock_request_n;
      stop_clock_request_s2 <= stop_clock_request_s1;
      probe_request_s1   <= probe_request_n;
      probe_request_s2   <= probe_request_s1;
      ferr_s1   <= fp_error_unmasked;
      ferr_s2   <= ferr_s1;
      brk_s1    <= break_event;
      brk_s2    <= brk_s1;
    end
  end

  assign stop_act = ~stop_clock_request_s2;

  always_comb begin
    next_break_hold = 1'b0;
    next_pin_n      = 1'b1;
    if (stop_act) begin
      next_break_hold = break_hold | brk_s2 | ~probe_request_s2;
      next_pin_n      = ~next_break_hold;
    end else begin
      next_pin_n = ~ferr_s2;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_hold               <= 1'b0;
      fp_error_break_pending_n <= 1'b1;
    end else begin
      break_hold               <= next_break_hold;
      fp_error_break_pending_n <= next_pin_n;
    end
  end

  property p_break_holds;
    @(posedge sys_clk) disable iff (!rst_n)
      (stop_act && !fp_error_break_pending_n && break_hold) ##1 stop_act
        |-> !fp_error_break_pending_n;
  endproperty
  a_break_holds: assert property (p_break_holds)
    else $error("break dropped early");

  property p_probe_break;
    @(posedge sys_clk) disable iff (!rst_n)
      (stop_act && !probe_request_s2) |=> !fp_error_break_pending_n;
  endproperty
  a_probe_break: assert property (p_probe_break) else $error("probe not a break");

  property p_break_report;
    @(posedge sys_clk) disable iff (!rst_n)
      (stop_act && brk_s2) |=> !fp_error_break_pending_n;
  endproperty
  a_break_report: assert property (p_break_report) else $error("break not shown");

  property p_ferr_report;
    @(posedge sys_clk) disable iff (!rst_n)
      !stop_act |=> (fp_error_break_pending_n == !$past(ferr_s2));
  endproperty
  a_ferr_report: assert property (p_ferr_report) else $error("fp error wrong");

  property p_no_break_when_run;
    @(posedge sys_clk) disable iff (!rst_n)
      !stop_act |=> !break_hold;
  endproperty
  a_no_break_when_run: assert property (p_no_break_when_run)
    else $error("stale break");

  property p_word_order;
    @(posedge link_clk) disable iff (!rst_n)
      (seen == {LANES{1'b1}}) |=> (hold_data[$past(hold_wr)] == $past(lane_q)) &&
        (link_tog != $past(link_tog));
  endproperty
  a_word_order: assert property (p_word_order)
    else $error("word not handed over");

  property p_lane0;
    @(posedge link_clk) disable iff (!rst_n)
      data_strobe_pos[0] |=> lane_q[LANE_W-1:0] ==
        ($past(lane_invert_flags[0]) ? ~$past(link_data[LANE_W-1:0])
                                     : $past(link_data[LANE_W-1:0]));
  endproperty
  a_lane0: assert property (p_lane0) else $error("lane 0 capture wrong");

  property p_inv_flag;
    @(posedge link_clk) disable iff (!rst_n)
      data_strobe_pos[LANES-1] |=> inv_q[LANES-1] == $past(lane_invert_flags[LANES-1]);
  endproperty
  a_inv_flag: assert property (p_inv_flag) else $error("flag capture wrong");

  property p_hold_advance;
    @(posedge link_clk) disable iff (!rst_n)
      (seen == {LANES{1'b1}}) |=> (hold_wr == HW'($past(hold_wr) + 1'b1));
  endproperty
  a_hold_advance: assert property (p_hold_advance)
    else $error("hold slot not advanced");

  property p_seen_restart;
    @(posedge link_clk) disable iff (!rst_n)
      (seen == {LANES{1'b1}}) |=> (seen == $past(data_strobe_pos));
  endproperty
  a_seen_restart: assert property (p_seen_restart)
    else $error("lane tracking not restarted");

  property p_word_queued;
    @(posedge sys_clk) disable iff (!rst_n)
      (new_word && buf_in_ready) |=> word_valid;
  endproperty
  a_word_queued: assert property (p_word_queued) else $error("word not queued");

  property p_overrun_set;
    @(posedge sys_clk) disable iff (!rst_n)
      (new_word && !buf_in_ready) |=> word_overrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("drop not flagged");

  property p_stop_masks_ferr;
    @(posedge sys_clk) disable iff (!rst_n)
      (stop_act && !break_hold && !brk_s2 && probe_request_s2) |=> fp_error_break_pending_n;
  endproperty
  a_stop_masks_ferr: assert property (p_stop_masks_ferr)
    else $error("fp error shown during stop");
endmodule

// ---- dsbe_link_model.sv ----
`timescale 1ns/1ps
module dsbe_link_model (
  output logic        link_clk,
  output logic [63:0] link_data,
  output logic [3:0]  lane_invert_flags,
  output logic [3:0]  data_strobe_pos
);
  logic [63:0] wire_last;
  logic [3:0]  inv_last;

  initial begin
    link_clk = 1'b0;
    link_data = 64'h0;
    lane_invert_flags = 4'h0;
    data_strobe_pos = 4'h0;
    wire_last = 64'h0;
    inv_last = 4'h0;
  end

  // One word per link cycle; lanes change only while the clock is low.
  task automatic send_one(input logic [63:0] w);
    logic [15:0] lane;
    for (int g = 0; g < 4; g++) begin
      lane = w[16*g +: 16];
      inv_last[g] = $countones(lane ^ wire_last[16*g +: 16]) > dsbe_pkg::INV_HALF;
      link_data[16*g +: 16] = inv_last[g] ? ~lane : lane;
    end
    lane_invert_flags = inv_last;
    data_strobe_pos = 4'hF;
    wire_last = link_data;
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask

  // One lane per link cycle, lane 0 first, to exercise word assembly.
  task automatic send_lanes(input logic [63:0] w);
    logic [15:0] lane;
    for (int g = 0; g < 4; g++) begin
      lane = w[16*g +: 16];
      inv_last[g] = $countones(lane ^ wire_last[16*g +: 16]) > dsbe_pkg::INV_HALF;
      link_data[16*g +: 16] = inv_last[g] ? ~lane : lane;
      wire_last[16*g +: 16] = link_data[16*g +: 16];
      lane_invert_flags = inv_last;
      data_strobe_pos = 4'h1 << g;
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask

  // Released lines show the inverse so a stale value can never pass for data.
  task automatic idle(input int n);
    data_strobe_pos = 4'h0;
    link_data = ~wire_last;
    lane_invert_flags = ~inv_last;
    repeat (n) begin
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask
endmodule

// ---- dsbe_top_tb_top.sv ----
`timescale 1ns/1ps
module dsbe_top_tb_top;
  logic                 sys_clk;
  logic                 rst_n;
  logic                 link_clk;
  logic [63:0]          link_data;
  logic [3:0]           lane_invert_flags;
  logic [3:0]           data_strobe_pos;
  logic                 word_valid;
  logic                 word_ready;
  dsbe_pkg::dsbe_word_t word;
  logic                 word_overrun;
  logic                 stop_clock_request_n;
  logic                 probe_request_n;
  logic                 fp_error_unmasked;
  logic                 break_event;
  logic                 fp_error_break_pending_n;
  int                   errors;
  int                   tests_run;

  dsbe_link_model dsbe_link_model_i (.link_clk(link_clk), .link_data(link_data),
    .lane_invert_flags(lane_invert_flags), .data_strobe_pos(data_strobe_pos));

  dsbe_top dsbe_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_data(link_data), .lane_invert_flags(lane_invert_flags),
    .data_strobe_pos(data_strobe_pos), .word_valid(word_valid), .word_ready(word_ready),
    .word(word), .word_overrun(word_overrun), .stop_clock_request_n(stop_clock_request_n),
    .probe_request_n(probe_request_n), .fp_error_unmasked(fp_error_unmasked),
    .break_event(break_event), .fp_error_break_pending_n(fp_error_break_pending_n));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic set_evt(input logic stop_n, input logic probe_n, input logic fp, input logic brk);
    @(negedge sys_clk);
    stop_clock_request_n = stop_n;
    probe_request_n = probe_n;
    fp_error_unmasked = fp;
    break_event = brk;
  endtask

  // The pin answers three cycles after an input change; four leaves margin.
  task automatic pin_after(input logic exp);
    repeat (4) @(negedge sys_clk);
    chk({68'h0, fp_error_break_pending_n}, {68'h0, exp});
  endtask

  task automatic take(input logic [67:0] exp);
    int n;
    n = 0;
    // Start on a falling edge so the ready pulse spans one rising edge.
    @(negedge sys_clk);
    while (word_valid !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk({word_valid, word}, {1'b1, exp});
    word_ready = 1'b1;
    @(negedge sys_clk);
    word_ready = 1'b0;
  endtask

  task automatic t_lanes();
    dsbe_link_model_i.idle(1);
    dsbe_link_model_i.send_one(64'h01FF_00FF_0001_FFFF);
    dsbe_link_model_i.idle(4);
    take({64'h01FF_00FF_0001_FFFF, 4'b1001});
    $display("test lanes done");
  endtask

  task automatic t_buffer();
    dsbe_link_model_i.send_one(64'hFE00_00FF_0001_0003);
    dsbe_link_model_i.send_one(64'hFE00_00FF_0001_0007);
    dsbe_link_model_i.send_one(64'hFE00_00FF_0001_000F);
    dsbe_link_model_i.idle(4);
    repeat (10) @(negedge sys_clk);
    chk({68'h0, word_overrun}, 69'h1);
    take({64'hFE00_00FF_0001_0003, 4'h0});
    take({64'hFE00_00FF_0001_0007, 4'h0});
    repeat (3) @(negedge sys_clk);
    chk({68'h0, word_valid}, 69'h0);
    $display("test buffer done");
  endtask

  task automatic t_split();
    dsbe_link_model_i.send_lanes(64'hFE00_FF00_0000_FFF0);
    dsbe_link_model_i.idle(4);
    take({64'hFE00_FF00_0000_FFF0, 4'h5});
    $display("test split done");
  endtask

  // A reset in mid-run must clear the sticky overrun and the pin.
  task automatic t_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({66'h0, fp_error_break_pending_n, word_valid, word_overrun}, 69'h4);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({66'h0, fp_error_break_pending_n, word_valid, word_overrun}, 69'h4);
    $display("test reset done");
  endtask

  task automatic t_pin();
    set_evt(1'b1, 1'b1, 1'b1, 1'b0);
    pin_after(1'b0);
    set_evt(1'b1, 1'b1, 1'b0, 1'b0);
    pin_after(1'b1);
    set_evt(1'b0, 1'b1, 1'b1, 1'b0);
    pin_after(1'b1);
    set_evt(1'b0, 1'b1, 1'b1, 1'b1);
    pin_after(1'b0);
    set_evt(1'b0, 1'b1, 1'b0, 1'b0);
    pin_after(1'b0);
    set_evt(1'b1, 1'b1, 1'b0, 1'b0);
    pin_after(1'b1);
    set_evt(1'b0, 1'b0, 1'b0, 1'b0);
    pin_after(1'b0);
    set_evt(1'b0, 1'b1, 1'b0, 1'b0);
    pin_after(1'b0);
    set_evt(1'b1, 1'b1, 1'b0, 1'b0);
    pin_after(1'b1);
    $display("test pin done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    word_ready = 1'b0;
    stop_clock_request_n = 1'b1;
    probe_request_n = 1'b1;
    fp_error_unmasked = 1'b0;
    break_event = 1'b0;
    // Link edges run alongside reset so both domains see it.
    fork
      dsbe_link_model_i.idle(2);
    join_none
    repeat (3) @(negedge sys_clk);
    chk({67'h0, fp_error_break_pending_n, word_valid}, 69'h2);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_lanes();
    t_buffer();
    t_split();
    t_reset();
    t_pin();
    report_and_stop();
  end
endmodule
